// ==== logic/sps_chopper.sv ====
/*
 * Constant off-time chopper of one full bridge with dead time,
 * blanking, minimum on-time and fast or slow decay patterns.
 * Assumes trip is a synchronous comparator level.
 */
`timescale 1ns/1ps
`include "sps_defs.svh"

module sps_chopper (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   // Control
   input wire logic bridge_en,
   input wire logic phase,
   input wire logic trip,
   input wire logic decay_slow,
   input wire logic [`SPS_OFF_W-1:0] off_cyc,
   // Results
   output sps_pkg::sps_gate_t gate,
   output sps_pkg::sps_chop_state_t state
);

   localparam logic [`SPS_TMR_W-1:0] DEAD_LAST =
      `SPS_TMR_W'(`SPS_DEAD_CYC - 1);
   localparam logic [`SPS_TMR_W-1:0] BLANK = `SPS_TMR_W'(`SPS_BLANK_CYC);
   localparam logic [`SPS_TMR_W-1:0] MINON = `SPS_TMR_W'(`SPS_MINON_CYC);

   logic [`SPS_OFF_W-1:0] cnt;
   logic [`SPS_TMR_W-1:0] on_cnt;
   logic ph_q;
   logic slow_q;
   logic all_off;
   logic trip_ok;
   sps_pkg::sps_gate_t next_gate;

   // Trip counts only after blanking and the least on-time
   assign trip_ok = trip && on_cnt >= BLANK && on_cnt >= MINON;

   always_ff @(posedge mclk) begin
      if (srst) begin
         state <= sps_pkg::SPS_CH_IDLE;
         cnt <= '0;
         on_cnt <= '0;
         ph_q <= 1'b0;
         slow_q <= 1'b0;
         all_off <= 1'b0;
      end else if (ce) begin
         if (!bridge_en) begin
            state <= sps_pkg::SPS_CH_IDLE;
         end else begin
            case (state)
               sps_pkg::SPS_CH_IDLE: begin
                  // A short disable must not skip the dead time
                  state <= sps_pkg::SPS_CH_DT_ON;
                  cnt <= '0;
                  all_off <= 1'b1;
                  ph_q <= phase;
               end
               sps_pkg::SPS_CH_ON: begin
                  if (phase != ph_q) begin
                     // Reversal swaps legs: all off for a dead time
                     state <= sps_pkg::SPS_CH_DT_ON;
                     cnt <= '0;
                     all_off <= 1'b1;
                     ph_q <= phase;
                  end else if (trip_ok) begin
                     state <= sps_pkg::SPS_CH_DT_OFF;
                     cnt <= '0;
                     slow_q <= decay_slow;
                  end else if (on_cnt != '1) begin
                     on_cnt <= on_cnt + 1'b1;
                  end
               end
               sps_pkg::SPS_CH_DT_OFF: begin
                  cnt <= cnt + 1'b1;
                  if (cnt[`SPS_TMR_W-1:0] == DEAD_LAST) begin
                     state <= sps_pkg::SPS_CH_RECIRC;
                  end
               end
               sps_pkg::SPS_CH_RECIRC: begin
                  cnt <= cnt + 1'b1;
                  if (cnt >= off_cyc - 1'b1) begin
                     state <= sps_pkg::SPS_CH_DT_ON;
                     cnt <= '0;
                  end
               end
               sps_pkg::SPS_CH_DT_ON: begin
                  cnt <= cnt + 1'b1;
                  // Follow a phase that moves while all gates are off,
                  // so no runt pulse of the old phase follows
                  if (all_off) begin
                     ph_q <= phase;
                  end
                  if (cnt[`SPS_TMR_W-1:0] == DEAD_LAST) begin
                     state <= sps_pkg::SPS_CH_ON;
                     on_cnt <= '0;
                     all_off <= 1'b0;
                  end
               end
               default: state <= sps_pkg::SPS_CH_IDLE;
            endcase
         end
      end
   end

   // Leg carrying the high side is leg 1 when phase is high
   always_comb begin
      next_gate = '0;
      case (state)
         sps_pkg::SPS_CH_ON: begin
            next_gate.hi1 = ph_q;
            next_gate.lo2 = ph_q;
            next_gate.hi2 = !ph_q;
            next_gate.lo1 = !ph_q;
         end
         sps_pkg::SPS_CH_DT_OFF, sps_pkg::SPS_CH_DT_ON: begin
            if (slow_q && !all_off) begin
               next_gate.hi1 = ph_q;
               next_gate.hi2 = !ph_q;
            end
         end
         sps_pkg::SPS_CH_RECIRC: begin
            if (slow_q) begin
               next_gate.hi1 = 1'b1;
               next_gate.hi2 = 1'b1;
            end else begin
               next_gate.lo1 = ph_q;
               next_gate.lo2 = !ph_q;
            end
         end
         default: next_gate = '0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         gate <= '0;
      end else if (ce) begin
         gate <= next_gate;
      end
   end

endmodule // sps_chopper

// ==== logic/sps_defs.svh ====
/*
 * Named constants of the stepper phase sequencer and bridge choppers:
 * timing figures, derived cycle counts, register map, fields, tables.
 * Assumes the block clock runs at SPS_CLK_MHZ.
 */
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH

// Block clock
`define SPS_CLK_MHZ 200

// Times in ns as printed
`define SPS_DEAD_NS 1000
`define SPS_BLANK_NS 1000
`define SPS_MINON_NS 1500
`define SPS_OFFMIN_NS 6600
`define SPS_OFFMAX_NS 6000000

// Cycle counts; least times round up, longest round down
`define SPS_DEAD_CYC ((`SPS_DEAD_NS * `SPS_CLK_MHZ + 999) / 1000)
`define SPS_BLANK_CYC ((`SPS_BLANK_NS * `SPS_CLK_MHZ + 999) / 1000)
`define SPS_MINON_CYC ((`SPS_MINON_NS * `SPS_CLK_MHZ + 999) / 1000)
`define SPS_OFF_MIN_CYC \
   ((`SPS_OFFMIN_NS * `SPS_CLK_MHZ + 999) / 1000 - `SPS_DEAD_CYC)
`define SPS_OFF_MAX_CYC \
   ((`SPS_OFFMAX_NS * `SPS_CLK_MHZ) / 1000 - `SPS_DEAD_CYC)

// Counter widths
`define SPS_OFF_W 21
`define SPS_TMR_W 9

// Register map (byte addresses)
`define SPS_ADDR_CTRL 8'h00
`define SPS_ADDR_OFF_A 8'h04
`define SPS_ADDR_OFF_B 8'h08
`define SPS_ADDR_STATUS 8'h0c

// Control fields and reset value
`define SPS_CTRL_EN_BIT 0
`define SPS_CTRL_SRST_BIT 1
`define SPS_CTRL_RST 32'h0000_0001

// Status fields
`define SPS_ST_IDX_LSB 0
`define SPS_ST_HALF_BIT 3
`define SPS_ST_EN_BIT 4
`define SPS_ST_CHA_LSB 5
`define SPS_ST_CHB_LSB 8
`define SPS_ST_FAULT_BIT 11

// Sequencer steps and first state (state 1 is index 0)
`define SPS_IDX_FIRST 3'h0
`define SPS_STEP_HALF 3'h1
`define SPS_STEP_FULL 3'h2

// Drive per state: {phase_a, en_a, phase_b, en_b}
`define SPS_TBL_S1 4'hf
`define SPS_TBL_S2 4'h3
`define SPS_TBL_S3 4'h7
`define SPS_TBL_S4 4'h4
`define SPS_TBL_S5 4'h5
`define SPS_TBL_S6 4'h1
`define SPS_TBL_S7 4'hd
`define SPS_TBL_S8 4'hc

`endif

// ==== logic/sps_pkg.sv ====
/*
 * Types shared by the sequencer top and the bridge chopper.
 * Assumes sps_defs.svh holds all numeric constants.
 */
package sps_pkg;

   // Gate commands of one full bridge, leg 1 and leg 2
   typedef struct packed {
      logic hi1;
      logic lo1;
      logic hi2;
      logic lo2;
   } sps_gate_t;

   // Drive of both bridges from the phase sequencer
   typedef struct packed {
      logic phase_a;
      logic en_a;
      logic phase_b;
      logic en_b;
   } sps_drive_t;

   // Chopper states, Gray coded along idle-on-dead-recirc-dead
   typedef enum logic [2:0] {
      SPS_CH_IDLE = 3'h0,
      SPS_CH_ON = 3'h1,
      SPS_CH_DT_OFF = 3'h3,
      SPS_CH_RECIRC = 3'h2,
      SPS_CH_DT_ON = 3'h6
   } sps_chop_state_t;

endpackage

// ==== logic/sps_top.sv ====
/*
 * Stepper phase sequencer with two bridge choppers and a Wishbone
 * classic register slave.
 * Assumes all pins are synchronous to mclk and that the pin
 * wire of the enable input is resolved outside from en_oe.
 */
// Local design decisions: register access over Wishbone and the register offsets.
// Summary of operation
// - State advances only on rising edges of the step clock.
// - Direction high counts state up, low counts down.
// - Power-up or reset input places sequencer in state 1.
// - Step size high selects half step through all eight states.
// - Half step visits 1..8 ascending, or descending with wrap.
// - Step size low in odd state gives two-phase-on full step.
// - Normal full step advances two states: 1,3,5,7 or 1,7,5,3.
// - Step size low in even state gives wave drive 2,4,6,8.
// - Phase and enable of both bridges follow the current state.
// - Each bridge chopper starts off interval when sense trips.
// - Total off period is off interval plus one dead time.
// - Off interval programmable from about 6.6 us to 6 ms; here from 1120 cycles (5.6 us), so total off period from 6.6 us.
// - Dead time of about 1 us between leg switch off and on.
// - Trip ignored for 1 us after the low side turns on.
// - On period never shorter than 1.5 us.
// - Decay low: fast decay, both conducting switches turned off.
// - Decay high: slow decay, only low side turned off.
// - Fast decay rectifies on lower switch only, uppers stay off.
// - Slow decay turns on recirculating upper switch after dead time.
// - Low side restarts only after a dead time, both decay modes.
// - Protection pulls enable low and disables both bridges.
`timescale 1ns/1ps
`include "sps_defs.svh"

module sps_top #(
   parameter logic [`SPS_OFF_W-1:0] OFF_MAX_CYC =
      `SPS_OFF_W'(`SPS_OFF_MAX_CYC)
) (
   // Clock, reset, clock enable
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   // Host logic inputs
   input wire logic step_clk,
   input wire logic rotation_direction,
   input wire logic step_size_select,
   input wire logic seq_reset,
   input wire logic decay_select,
   // Enable pin, open drain pull-down by protection
   input wire logic en_in,
   output logic en_out,
   output logic en_oe,
   // Protection and sense comparators
   input wire logic prot_fault,
   input wire logic current_sense_a,
   input wire logic current_sense_b,
   // Bridge drive
   output sps_pkg::sps_gate_t gate_a,
   output sps_pkg::sps_gate_t gate_b,
   output logic phase_a,
   output logic phase_b,
   output logic bridge_en_a,
   output logic bridge_en_b,
   // Wishbone classic slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack
);

   localparam logic [`SPS_OFF_W-1:0] OFF_MIN =
      `SPS_OFF_W'(`SPS_OFF_MIN_CYC);

   logic step_prev;
   logic step_edge;
   logic [2:0] seq_idx;
   logic [2:0] step_inc;
   logic [2:0] next_idx;
   sps_pkg::sps_drive_t drive;
   logic [31:0] ctrl;
   logic soft_reset;
   logic [`SPS_OFF_W-1:0] off_reg [2];
   logic glob_en;
   logic [1:0] sense;
   logic [1:0] br_en;
   logic [1:0] br_ph;
   sps_pkg::sps_gate_t gate [2];
   sps_pkg::sps_chop_state_t chop_st [2];
   logic wb_req;
   logic wb_wr;
   logic [31:0] next_rdata;

   // Table of drive per state, states 1..8 at index 0..7
   function automatic sps_pkg::sps_drive_t seq_decode(
      input logic [2:0] idx
   );
      case (idx)
         3'h0: seq_decode = `SPS_TBL_S1;
         3'h1: seq_decode = `SPS_TBL_S2;
         3'h2: seq_decode = `SPS_TBL_S3;
         3'h3: seq_decode = `SPS_TBL_S4;
         3'h4: seq_decode = `SPS_TBL_S5;
         3'h5: seq_decode = `SPS_TBL_S6;
         3'h6: seq_decode = `SPS_TBL_S7;
         default: seq_decode = `SPS_TBL_S8;
      endcase
   endfunction

   // Byte-lane merge of a write into a register
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old,
      input logic [31:0] data,
      input logic [3:0] sel
   );
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      lane_merge = res;
   endfunction

   // Keep a programmed off interval inside its documented range
   function automatic logic [`SPS_OFF_W-1:0] off_clamp(
      input logic [31:0] val
   );
      if (val < 32'(OFF_MIN)) begin
         off_clamp = OFF_MIN;
      end else if (val > 32'(OFF_MAX_CYC)) begin
         off_clamp = OFF_MAX_CYC;
      end else begin
         off_clamp = val[`SPS_OFF_W-1:0];
      end
   endfunction

   // Phase sequencer

   always_ff @(posedge mclk) begin
      if (srst) begin
         step_prev <= 1'b0;
      end else if (ce) begin
         step_prev <= step_clk;
      end
   end

   assign step_edge = step_clk && !step_prev;

   // Full step moves two states, so parity of the state picks
   // normal or wave drive without any extra mode register
   assign step_inc = step_size_select ? `SPS_STEP_HALF
                                      : `SPS_STEP_FULL;
   assign next_idx = rotation_direction ? seq_idx + step_inc
                                        : seq_idx - step_inc;

   always_ff @(posedge mclk) begin
      if (srst) begin
         seq_idx <= `SPS_IDX_FIRST;
      end else if (ce) begin
         if (seq_reset || soft_reset) begin
            seq_idx <= `SPS_IDX_FIRST;
         end else if (step_edge) begin
            seq_idx <= next_idx;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         drive <= '0;
      end else if (ce) begin
         drive <= seq_decode(seq_idx);
      end
   end

   // Protection and enable

   // The pin alone lags the pull-down, so the fault gates directly
   assign glob_en = en_in && !prot_fault && ctrl[`SPS_CTRL_EN_BIT];

   always_ff @(posedge mclk) begin
      if (srst) begin
         en_oe <= 1'b0;
         en_out <= 1'b0;
      end else if (ce) begin
         en_oe <= prot_fault;
         en_out <= 1'b0;
      end
   end

   // Bridge choppers

   assign sense = {current_sense_b, current_sense_a};
   assign br_en = {drive.en_b && glob_en, drive.en_a && glob_en};
   assign br_ph = {drive.phase_b, drive.phase_a};

   generate
      for (genvar b = 0; b < 2; b++) begin : g_bridge
         sps_chopper u_chop (
            .mclk(mclk),
            .srst(srst),
            .ce(ce),
            .bridge_en(br_en[b]),
            .phase(br_ph[b]),
            .trip(sense[b]),
            .decay_slow(decay_select),
            .off_cyc(off_reg[b]),
            .gate(gate[b]),
            .state(chop_st[b])
         );
      end
   endgenerate

   assign gate_a = gate[0];
   assign gate_b = gate[1];

   always_ff @(posedge mclk) begin
      if (srst) begin
         phase_a <= 1'b0;
         phase_b <= 1'b0;
         bridge_en_a <= 1'b0;
         bridge_en_b <= 1'b0;
      end else if (ce) begin
         phase_a <= drive.phase_a;
         phase_b <= drive.phase_b;
         bridge_en_a <= br_en[0];
         bridge_en_b <= br_en[1];
      end
   end

   // Wishbone classic slave, one wait state

   assign wb_req = wb_cyc && wb_stb && !wb_ack;
   assign wb_wr = wb_req && wb_we;

   always_ff @(posedge mclk) begin
      if (srst) begin
         wb_ack <= 1'b0;
      end else if (ce) begin
         wb_ack <= wb_req;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl <= `SPS_CTRL_RST;
         soft_reset <= 1'b0;
      end else if (ce) begin
         soft_reset <= 1'b0;
         if (wb_wr && wb_adr == `SPS_ADDR_CTRL) begin
            ctrl <= lane_merge(ctrl, wb_dat_w, wb_sel) &
                    (32'h1 << `SPS_CTRL_EN_BIT);
            soft_reset <= wb_sel[0] && wb_dat_w[`SPS_CTRL_SRST_BIT];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         off_reg[0] <= OFF_MIN;
         off_reg[1] <= OFF_MIN;
      end else if (ce && wb_wr) begin
         if (wb_adr == `SPS_ADDR_OFF_A) begin
            off_reg[0] <= off_clamp(lane_merge(32'(off_reg[0]),
                                               wb_dat_w, wb_sel));
         end else if (wb_adr == `SPS_ADDR_OFF_B) begin
            off_reg[1] <= off_clamp(lane_merge(32'(off_reg[1]),
                                               wb_dat_w, wb_sel));
         end
      end
   end

   always_comb begin
      next_rdata = '0;
      if (wb_adr == `SPS_ADDR_CTRL) begin
         next_rdata = ctrl;
      end else if (wb_adr == `SPS_ADDR_OFF_A) begin
         next_rdata = 32'(off_reg[0]);
      end else if (wb_adr == `SPS_ADDR_OFF_B) begin
         next_rdata = 32'(off_reg[1]);
      end else if (wb_adr == `SPS_ADDR_STATUS) begin
         next_rdata[`SPS_ST_IDX_LSB +: 3] = seq_idx;
         next_rdata[`SPS_ST_HALF_BIT] = step_size_select;
         next_rdata[`SPS_ST_EN_BIT] = glob_en;
         next_rdata[`SPS_ST_CHA_LSB +: 3] = chop_st[0];
         next_rdata[`SPS_ST_CHB_LSB +: 3] = chop_st[1];
         next_rdata[`SPS_ST_FAULT_BIT] = prot_fault;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wb_dat_r <= '0;
      end else if (ce && wb_req && !wb_we) begin
         wb_dat_r <= next_rdata;
      end
   end

endmodule // sps_top

// ==== testbench/sps_host_model.sv ====
/*
 * Host controller model driving the step, direction, size, decay
 * and sequencer reset pins of the sequencer.
 * Assumes its tasks are called from one bench process only.
 */
`timescale 1ns/1ps

module sps_host_model (
   // Clock
   input wire logic mclk,
   // Logic pins toward the device
   output logic step_clk,
   output logic rotation_direction,
   output logic step_size_select,
   output logic seq_reset,
   output logic decay_select
);
   initial begin
      step_clk = 1'b0;
      rotation_direction = 1'b1;
      step_size_select = 1'b1;
      seq_reset = 1'b0;
      decay_select = 1'b0;
   end

   // Mode pins settle a cycle ahead of the next step edge
   task automatic mode(input logic dir, input logic size, input logic dec);
      @(posedge mclk);
      rotation_direction <= dir;
      step_size_select <= size;
      decay_select <= dec;
   endtask

   // Held high, then low, long enough for the drive to follow
   task automatic step();
      @(posedge mclk);
      step_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      step_clk <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   // With size low this leaves the sequencer in odd state 1
   task automatic reset_seq();
      @(posedge mclk);
      seq_reset <= 1'b1;
      repeat (4) @(posedge mclk);
      seq_reset <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
endmodule // sps_host_model

// ==== testbench/sps_top_properties.sv ====
/*
 * Pin-level checker of the sequencer drive, bridge A gates, enable
 * pull-down and Wishbone handshake.
 * Assumes a single clock domain with srst as synchronous reset.
 */
`timescale 1ns/1ps
`include "sps_defs.svh"

module sps_top_properties (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Watched pins
   input wire logic seq_reset,
   input wire logic en_in,
   input wire logic prot_fault,
   input wire logic en_oe,
   input wire sps_pkg::sps_gate_t gate_a,
   input wire logic phase_a,
   input wire logic phase_b,
   input wire logic bridge_en_a,
   input wire logic bridge_en_b,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_ack
);
   localparam int DEAD = `SPS_DEAD_CYC;
   localparam int MIN_ON = `SPS_MINON_CYC;
   logic [9:0] hi2_idle;
   logic [9:0] lo2_idle;
   logic [9:0] on_len;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   // Idle counters start saturated so the first turn-on is legal
   always_ff @(posedge mclk) begin
      if (srst) hi2_idle <= 10'h3ff;
      else if (gate_a.hi2) hi2_idle <= 10'h0;
      else if (hi2_idle != 10'h3ff) hi2_idle <= hi2_idle + 10'h1;
   end
   always_ff @(posedge mclk) begin
      if (srst) lo2_idle <= 10'h3ff;
      else if (gate_a.lo2) lo2_idle <= 10'h0;
      else if (lo2_idle != 10'h3ff) lo2_idle <= lo2_idle + 10'h1;
   end
   always_ff @(posedge mclk) begin
      if (srst || !gate_a.lo2) on_len <= 10'h0;
      else if (on_len != 10'h3ff) on_len <= on_len + 10'h1;
   end

   AST_LEG_EXCL: assert property (
      !(gate_a.hi1 && gate_a.lo1) && !(gate_a.hi2 && gate_a.lo2))
      else $error("leg shoot-through on bridge A");
   AST_DEAD_LO: assert property (
      $rose(gate_a.lo2) |-> hi2_idle >= DEAD)
      else $error("low side on too soon after high side");
   AST_DEAD_HI: assert property (
      $rose(gate_a.hi2) |-> lo2_idle >= DEAD)
      else $error("high side on too soon after low side");
   AST_MIN_ON: assert property (
      $fell(gate_a.lo2) && phase_a && bridge_en_a && $past(phase_a, 4)
      && $past(bridge_en_a, 4) |-> on_len >= MIN_ON)
      else $error("on period shorter than minimum");
   AST_SEQ_HOME: assert property (
      seq_reset [*4] |-> phase_a && phase_b)
      else $error("sequencer not in first state under reset");
   AST_FAULT_OE: assert property (
      en_oe == $past(prot_fault))
      else $error("enable pull-down does not follow fault");
   AST_FAULT_OFF: assert property (
      prot_fault |=> !bridge_en_a && !bridge_en_b)
      else $error("bridges enabled during fault");
   AST_EN_LOW: assert property (
      !en_in [*3] |-> !bridge_en_a && !bridge_en_b)
      else $error("bridges enabled with enable wire low");
   AST_GATE_IDLE: assert property (
      !bridge_en_a [*3] |-> gate_a == 4'h0)
      else $error("gates driven on a disabled bridge");
   AST_ACK_NEXT: assert property (
      wb_cyc && wb_stb && !wb_ack |=> wb_ack)
      else $error("register access not answered next cycle");
   AST_ACK_PULSE: assert property (
      wb_ack |=> !wb_ack)
      else $error("acknowledge longer than one cycle");

   cover property ($rose(gate_a.hi2));
   cover property ($fell(gate_a.lo2) && bridge_en_a);
   cover property (prot_fault ##1 en_oe);
endmodule // sps_top_properties

bind sps_top sps_top_properties chk_u (.mclk(mclk), .srst(srst),
   .seq_reset(seq_reset), .en_in(en_in), .prot_fault(prot_fault),
   .en_oe(en_oe), .gate_a(gate_a), .phase_a(phase_a), .phase_b(phase_b),
   .bridge_en_a(bridge_en_a), .bridge_en_b(bridge_en_b),
   .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_ack(wb_ack));

// ==== testbench/sps_top_tb.sv ====
/*
 * Self-checking bench: step modes, drive table, choppers, enable
 * pull-down and registers of the sequencer top.
 * Assumes the host model drives the logic pins.
 */
`timescale 1ns/1ps
`include "sps_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
   fails++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module sps_top_tb;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic host_en = 1'b1;
   logic prot_fault = 1'b0;
   logic sense_a = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dat_w = 32'h0;
   logic [31:0] wb_dat_r;
   logic wb_ack, en_in, en_out, en_oe, phase_a, phase_b;
   logic bridge_en_a, bridge_en_b, step_clk, dir, size, seq_rst, dec;
   sps_pkg::sps_gate_t gate_a;
   sps_pkg::sps_gate_t gate_b;
   logic [31:0] q;
   int fails = 0;
   int check_count = 0;
   logic [3:0] tbl [8] = '{`SPS_TBL_S1, `SPS_TBL_S2, `SPS_TBL_S3,
      `SPS_TBL_S4, `SPS_TBL_S5, `SPS_TBL_S6, `SPS_TBL_S7, `SPS_TBL_S8};

   // Open-drain enable wire with pull-up behind the host driver
   assign en_in = en_oe ? en_out : host_en;
   logic [3:0] drv;
   assign drv = {phase_a, bridge_en_a, phase_b, bridge_en_b};

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   sps_host_model host_u (.mclk(mclk), .step_clk(step_clk),
      .rotation_direction(dir), .step_size_select(size),
      .seq_reset(seq_rst), .decay_select(dec));

   sps_top #(.OFF_MAX_CYC(21'd2000)) dut_u (.mclk(mclk), .srst(srst),
      .ce(1'b1), .step_clk(step_clk), .rotation_direction(dir),
      .step_size_select(size), .seq_reset(seq_rst), .decay_select(dec),
      .en_in(en_in), .en_out(en_out), .en_oe(en_oe),
      .prot_fault(prot_fault), .current_sense_a(sense_a),
      .current_sense_b(1'b0), .gate_a(gate_a), .gate_b(gate_b),
      .phase_a(phase_a), .phase_b(phase_b), .bridge_en_a(bridge_en_a),
      .bridge_en_b(bridge_en_b), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hf),
      .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

   task automatic wrap_up();
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic guard(input int n);
      if (n >= 5000) begin
         fails++;
         wrap_up();
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat_w <= d;
      do begin
         @(posedge mclk);
         n++;
         guard(n);
      end while (wb_ack !== 1'b1);
      q = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic walk(input logic d, input logic s, input int st,
      input int inc);
      host_u.mode(d, s, 1'b0);
      for (int i = 0; i < 8; i++) begin
         host_u.step();
         st = (st + inc + 8) % 8;
         `CHK("drive", tbl[st], drv)
      end
   endtask

   task automatic t_half();
      host_u.mode(1'b1, 1'b1, 1'b0);
      host_u.reset_seq();
      `CHK("home", tbl[0], drv)
      walk(1'b1, 1'b1, 0, 1);
      walk(1'b0, 1'b1, 0, -1);
   endtask

   task automatic t_full();
      host_u.mode(1'b1, 1'b0, 1'b0);
      host_u.reset_seq();
      walk(1'b1, 1'b0, 0, 2);
      walk(1'b0, 1'b0, 0, -2);
   endtask

   task automatic t_wave();
      host_u.mode(1'b1, 1'b1, 1'b0);
      host_u.reset_seq();
      host_u.step();
      walk(1'b1, 1'b0, 1, 2);
      walk(1'b0, 1'b0, 1, -2);
      wb(1'b1, 8'h00, 32'h3);
      repeat (4) @(posedge mclk);
      `CHK("soft_rst", tbl[0], drv)
      wb(1'b0, 8'h00, 32'h0);
      `CHK("ctrl_rd", 32'h1, q)
   endtask

   task automatic t_regs();
      wb(1'b0, 8'h00, 32'h0);
      `CHK("ctrl", 32'h1, q)
      wb(1'b1, 8'h04, 32'd5);
      wb(1'b0, 8'h04, 32'h0);
      `CHK("offmin", 32'(`SPS_OFF_MIN_CYC), q)
      wb(1'b1, 8'h04, 32'd1500);
      wb(1'b0, 8'h04, 32'h0);
      `CHK("off", 32'd1500, q)
      wb(1'b1, 8'h10, 32'hffff);
      wb(1'b0, 8'h10, 32'h0);
      `CHK("unmapped", 32'h0, q)
      wb(1'b1, 8'h00, 32'h0);
      repeat (4) @(posedge mclk);
      `CHK("soft_off", 1'b0, bridge_en_a)
      wb(1'b0, 8'h0c, 32'h0);
      `CHK("status", 32'h8, q)
      wb(1'b1, 8'h00, 32'h1);
   endtask

   // Counts cycles while the gates do, or do not, match g
   task automatic run(input logic [3:0] g, input logic eq, inout int n);
      while ((gate_a === g) == eq) begin
         @(posedge mclk);
         n++;
         guard(n);
      end
   endtask

   task automatic chop(input logic slow, input logic [3:0] edt,
      input logic [3:0] erec);
      int n;
      int m;
      n = 0;
      m = 0;
      host_u.mode(1'b1, 1'b1, slow);
      host_u.reset_seq();
      run(4'h9, 1'b0, n);
      `CHK("gate_b", 4'h9, gate_b)
      sense_a <= 1'b1;
      run(4'h9, 1'b1, n);
      `CHK("dt_off", edt, gate_a)
      run(edt, 1'b1, m);
      `CHK("dead", `SPS_DEAD_CYC, m)
      `CHK("recirc", erec, gate_a)
      run(4'h9, 1'b0, m);
      `CHK("off_total", 1500 + `SPS_DEAD_CYC, m)
      n = 0;
      run(4'h9, 1'b1, n);
      `CHK("on_len", 1'b1, n >= `SPS_MINON_CYC)
      sense_a <= 1'b0;
      run(4'h9, 1'b0, n);
   endtask

   task automatic t_fault();
      @(posedge mclk);
      prot_fault <= 1'b1;
      repeat (3) @(posedge mclk);
      `CHK("pull", 1'b1, en_oe)
      `CHK("fault_off", 1'b0, bridge_en_a)
      prot_fault <= 1'b0;
      host_en <= 1'b0;
      repeat (4) @(posedge mclk);
      `CHK("release", 1'b0, en_oe)
      `CHK("host_off", 1'b0, bridge_en_b)
      host_en <= 1'b1;
      repeat (4) @(posedge mclk);
      `CHK("back_on", 1'b1, bridge_en_a)
   endtask

   initial begin
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      repeat (4) @(posedge mclk);
      t_regs();
      t_half();
      t_full();
      t_wave();
      chop(1'b0, 4'h0, 4'h4);
      chop(1'b1, 4'h8, 4'ha);
      t_fault();
      wrap_up();
   end
endmodule // sps_top_tb
